//--- secchk_pkg.sv
// Package for the setup error checker: encodings, error codes, request layout.
// Assumes a single clock domain; all users reference items as secchk_pkg::name.
`default_nettype none
package secchk_pkg;
	// Source selection encodings for process value and set point
	localparam logic [2:0] SRC_FIRST_INPUT  = 3'h0; // first_input_value
	localparam logic [2:0] SRC_SECOND_INPUT = 3'h1; // second_input_value
	localparam logic [2:0] SRC_DIFF_1M2     = 3'h2; // input_diff_one_minus_two
	localparam logic [2:0] SRC_DIFF_2M1     = 3'h3; // input_diff_two_minus_one
	localparam logic [2:0] SRC_OTHER        = 3'h4; // Keypad, remote or other source

	// Secondary output assignment encodings
	localparam logic [1:0] SECONDARY_OUTPUT_CFG_NONE    = 2'h0;
	localparam logic [1:0] SECONDARY_OUTPUT_CFG_COOLING = 2'h1; // cooling_output_choice
	localparam logic [1:0] SECONDARY_OUTPUT_CFG_ALARM2  = 2'h2; // alarm_two_output_choice
	// Primary output action encodings
	localparam logic       PRIMARY_OUTPUT_CFG_REVERSE = 1'h0; // Heating action
	localparam logic       PRIMARY_OUTPUT_CFG_DIRECT  = 1'h1; // direct_action_choice

	// Alarm function encodings
	localparam logic [3:0] ALM_NONE      = 4'h0;
	localparam logic [3:0] ALM_DWELL     = 4'h1; // dwell_timer_choice
	localparam logic [3:0] ALM_COMB_HIGH = 4'h2; // combined_input_high_alarm
	localparam logic [3:0] ALM_COMB_LOW  = 4'h3; // combined_input_low_alarm
	localparam logic [3:0] ALM_DIFF_HIGH = 4'h4; // diff_input_high_alarm
	localparam logic [3:0] ALM_DIFF_LOW  = 4'h5; // diff_input_low_alarm

	// Host function codes that the device accepts
	localparam logic [7:0] FC_READ  = 8'h03;
	localparam logic [7:0] FC_WRITE = 8'h06;

	// Error codes shown on the panel
	localparam logic [5:0] ERR_NONE       = 6'h00;
	localparam logic [5:0] ERR_PV1_BOTH   = 6'h01;
	localparam logic [5:0] ERR_PV2_BOTH   = 6'h02;
	localparam logic [5:0] ERR_DIFF_SRC   = 6'h03;
	localparam logic [5:0] ERR_COOLING_OUTPUT_CHOICE_CFG   = 6'h04;
	localparam logic [5:0] ERR_UNIT_DP    = 6'h05;
	localparam logic [5:0] ERR_AL2_NONE   = 6'h06;
	localparam logic [5:0] ERR_DWELL_BOTH = 6'h07;
	localparam logic [5:0] ERR_BAD_FUNC   = 6'h0a;
	localparam logic [5:0] ERR_ADDR_RANGE = 6'h0b;
	localparam logic [5:0] ERR_NO_PARAM   = 6'h0c;
	localparam logic [5:0] ERR_READ_ONLY  = 6'h0e;
	localparam logic [5:0] ERR_VAL_RANGE  = 6'h0f;

	// Setup parameters checked for consistency
	typedef struct packed {
		logic [2:0]  pv_src;       // process_value_source_sel
		logic [2:0]  sp_src;       // set_point_source_sel
		logic        primary_output_cfg_action;  // primary_output_cfg action
		logic [1:0]  secondary_output_cfg_func;    // secondary_output_cfg
		logic [15:0] pb_a;         // prop_band_set_a
		logic [15:0] pb_b;         // prop_band_set_b
		logic [15:0] ti_a;         // integral_time_set_a
		logic [15:0] ti_b;         // integral_time_set_b
		logic [1:0]  in1_unit;     // input_one_unit
		logic [1:0]  in2_unit;     // input_two_unit
		logic [1:0]  in1_dp;       // input_one_decimal_pos
		logic [1:0]  in2_dp;       // input_two_decimal_pos
		logic [3:0]  alm1_func;    // alarm_one_function
		logic [3:0]  alm2_func;    // alarm_two_function
	} secchk_setup_t;

	// One host request, valid for one cycle
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  func;
		logic [15:0] addr;
		logic [15:0] data;
	} secchk_req_t;

	// Outcome of one classified request
	typedef struct packed {
		logic       done;     // One-cycle pulse
		logic       accepted; // Write may be committed
		logic [5:0] code;     // ERR_NONE when accepted
	} secchk_resp_t;
endpackage
`default_nettype wire

//--- secchk_req_class.sv
// Host request classifier: turns one request into an error code.
// Assumes a per-address attribute table supplied by the parent as flat vectors.
`default_nettype none
module secchk_req_class #(
	parameter int unsigned NREG = 64 // Implemented register count
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  clk_en_i,
	input  wire secchk_pkg::secchk_req_t req_i,
	input  wire logic [NREG-1:0]       exists_i,   // Parameter exists at index
	input  wire logic [NREG-1:0]       ro_i,       // Read-only or protected
	input  wire logic [15:0]           min_i,      // Limit of addressed register
	input  wire logic [15:0]           max_i,
	output logic [$clog2(NREG)-1:0]    idx_o,      // Index for limit lookup
	output var secchk_pkg::secchk_resp_t resp_o
);
	logic [5:0] code_d; // Classification of the current request
	logic       in_rng; // Address inside implemented range

	assign in_rng = (req_i.addr < 16'(NREG));
	assign idx_o  = req_i.addr[$clog2(NREG)-1:0];

	// Checks in code order so the lowest number wins
	always_comb begin
		code_d = secchk_pkg::ERR_NONE;
		if (req_i.func != secchk_pkg::FC_READ && req_i.func != secchk_pkg::FC_WRITE) begin
			code_d = secchk_pkg::ERR_BAD_FUNC; // RQ9
		end else if (!in_rng) begin
			code_d = secchk_pkg::ERR_ADDR_RANGE; // RQ10
		end else if (!exists_i[idx_o]) begin
			code_d = secchk_pkg::ERR_NO_PARAM; // RQ11
		end else if (req_i.write && ro_i[idx_o]) begin
			code_d = secchk_pkg::ERR_READ_ONLY; // RQ12
		end else if (req_i.write && (req_i.data < min_i || req_i.data > max_i)) begin
			code_d = secchk_pkg::ERR_VAL_RANGE; // RQ14
		end
	end

	// Registered answer, one cycle after the request
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			resp_o <= '0;
		end else if (clk_en_i) begin
			resp_o.done     <= req_i.valid;
			resp_o.accepted <= req_i.valid && req_i.write && (code_d == secchk_pkg::ERR_NONE);
			resp_o.code     <= req_i.valid ? code_d : secchk_pkg::ERR_NONE;
		end
	end
endmodule // secchk_req_class
`default_nettype wire

//--- secchk_top.sv
// Setup error checker: setup consistency checks and host request errors.
// Assumes setup and request inputs synchronous to ref_clk_i at 10 MHz.
// Behaviour
// (RQ1) Input one as PV and SP: code 1
// (RQ2) Input two as PV and SP: code 2
// (RQ3) Difference PV with single-input SP: code 3
// (RQ4) Cooling secondary_output_cfg with direct or non-PID primary_output_cfg: 4
// (RQ5) Unit or decimal mismatch when combined: 5
// (RQ6) Secondary_output_cfg alarm two, alarm two none: 6
// (RQ7) Then secondary_output_cfg drives no alarm
// (RQ8) Dwell timer on both alarms: code 7
// (RQ9) Unsupported function code: code 10
// (RQ10) Address beyond implemented range: code 11
// (RQ11) Nonexistent parameter: code 12
// (RQ12) Write to read-only: code 14, unchanged
// (RQ13) Host avoids illegal writes and addresses
// (RQ14) Out-of-range write value: code 15, rejected
// (RQ15) Lowest active code shown while it holds
// (RQ16) Checks re-evaluated within one cycle
`default_nettype none
module secchk_top #(
	parameter int unsigned NREG = 64 // Implemented register count
) (
	input  wire logic                    ref_clk_i,
	input  wire logic                    sys_rst_i,
	input  wire logic                    clk_en_i,
	input  wire secchk_pkg::secchk_setup_t setup_i,     // Current setup parameters
	input  wire logic                    alarm2_raw_i,  // Alarm two decision from the loop
	input  wire secchk_pkg::secchk_req_t   req_i,       // Host request, one-cycle valid
	input  wire logic [NREG-1:0]         reg_exists_i,  // Parameter map
	input  wire logic [NREG-1:0]         reg_ro_i,      // Read-only map
	input  wire logic [15:0]             lim_min_i,     // Limits for addressed register
	input  wire logic [15:0]             lim_max_i,
	input  wire logic                    comm_err_clr_i, // Clears held host error
	output logic [$clog2(NREG)-1:0]      lim_idx_o,     // Address used for limit lookup
	output var secchk_pkg::secchk_resp_t resp_o,        // Per-request answer
	output logic                         wr_commit_o,   // Write may be stored
	output logic                         secondary_output_cfg_alarm_o,  // Alarm drive on output two
	output logic [5:0]                   err_code_o     // Code shown on the panel
);
	secchk_pkg::secchk_setup_t s; // Short alias
	logic c1, c2, c3, c4, c5, c6, c7; // Setup condition flags
	logic pv_diff, sp_single, pv_single, comb_alarm; // Helper terms
	logic [5:0] setup_code; // Lowest active setup code
	logic [5:0] comm_q;     // Held host error code
	logic [5:0] err_q;      // Displayed code register
	logic [5:0] err_d;

	assign s = setup_i;
	assign pv_diff   = (s.pv_src == secchk_pkg::SRC_DIFF_1M2) ||
	                   (s.pv_src == secchk_pkg::SRC_DIFF_2M1);
	assign pv_single = (s.pv_src == secchk_pkg::SRC_FIRST_INPUT) ||
	                   (s.pv_src == secchk_pkg::SRC_SECOND_INPUT);
	assign sp_single = (s.sp_src == secchk_pkg::SRC_FIRST_INPUT) ||
	                   (s.sp_src == secchk_pkg::SRC_SECOND_INPUT);
	// Alarms that read both inputs at once
	assign comb_alarm =
		(s.alm1_func inside {secchk_pkg::ALM_COMB_HIGH, secchk_pkg::ALM_COMB_LOW,
		                     secchk_pkg::ALM_DIFF_HIGH, secchk_pkg::ALM_DIFF_LOW}) ||
		(s.alm2_func inside {secchk_pkg::ALM_COMB_HIGH, secchk_pkg::ALM_COMB_LOW,
		                     secchk_pkg::ALM_DIFF_HIGH, secchk_pkg::ALM_DIFF_LOW});

	// Setup conditions are pure combinational so any change shows next edge
	assign c1 = (s.pv_src == secchk_pkg::SRC_FIRST_INPUT) &&
	            (s.sp_src == secchk_pkg::SRC_FIRST_INPUT); // RQ1
	assign c2 = (s.pv_src == secchk_pkg::SRC_SECOND_INPUT) &&
	            (s.sp_src == secchk_pkg::SRC_SECOND_INPUT); // RQ2
	assign c3 = pv_diff && sp_single; // RQ3
	// Cooling needs reverse-acting PID on output one
	assign c4 = (s.secondary_output_cfg_func == secchk_pkg::SECONDARY_OUTPUT_CFG_COOLING) &&
	            ((s.primary_output_cfg_action == secchk_pkg::PRIMARY_OUTPUT_CFG_DIRECT) ||
	             (s.pb_a == '0) || (s.pb_b == '0) ||
	             (s.ti_a == '0) || (s.ti_b == '0)); // RQ4
	// Inputs combined when PV is a difference, SP is an input while PV is too, or an alarm mixes them
	assign c5 = ((s.in1_unit != s.in2_unit) || (s.in1_dp != s.in2_dp)) &&
	            (pv_diff || (sp_single && pv_single) || comb_alarm); // RQ5
	assign c6 = (s.secondary_output_cfg_func == secchk_pkg::SECONDARY_OUTPUT_CFG_ALARM2) &&
	            (s.alm2_func == secchk_pkg::ALM_NONE); // RQ6
	assign c7 = (s.alm1_func == secchk_pkg::ALM_DWELL) &&
	            (s.alm2_func == secchk_pkg::ALM_DWELL); // RQ8

	// Priority encoder, lowest code first
	always_comb begin
		if (c1)      setup_code = secchk_pkg::ERR_PV1_BOTH; // RQ15
		else if (c2) setup_code = secchk_pkg::ERR_PV2_BOTH;
		else if (c3) setup_code = secchk_pkg::ERR_DIFF_SRC;
		else if (c4) setup_code = secchk_pkg::ERR_COOLING_OUTPUT_CHOICE_CFG;
		else if (c5) setup_code = secchk_pkg::ERR_UNIT_DP;
		else if (c6) setup_code = secchk_pkg::ERR_AL2_NONE;
		else if (c7) setup_code = secchk_pkg::ERR_DWELL_BOTH;
		else         setup_code = secchk_pkg::ERR_NONE;
	end

	// Request classifier
	secchk_req_class #(.NREG(NREG)) u_class (
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.clk_en_i  (clk_en_i),
		.req_i     (req_i),
		.exists_i  (reg_exists_i),
		.ro_i      (reg_ro_i),
		.min_i     (lim_min_i),
		.max_i     (lim_max_i),
		.idx_o     (lim_idx_o),
		.resp_o    (resp_o)
	);

	// Only clean writes may be stored; refused values leave the item unchanged
	assign wr_commit_o = resp_o.accepted; // RQ12 RQ14

	// Host error holds until cleared; a new error wins over a same-cycle clear
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			comm_q <= secchk_pkg::ERR_NONE;
		end else if (clk_en_i) begin
			if (resp_o.done && resp_o.code != secchk_pkg::ERR_NONE) begin
				comm_q <= resp_o.code;
			end else if (comm_err_clr_i) begin
				comm_q <= secchk_pkg::ERR_NONE;
			end
		end
	end

	// Setup codes are lower than host codes, so they take the display first
	always_comb begin
		err_d = (setup_code != secchk_pkg::ERR_NONE) ? setup_code : comm_q; // RQ15
	end

	// Display register follows the active code each cycle
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			err_q <= secchk_pkg::ERR_NONE;
		end else if (clk_en_i) begin
			err_q <= err_d; // RQ16
		end
	end
	assign err_code_o = err_q;

	// Output two alarm drive, suppressed when alarm two has no function
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			secondary_output_cfg_alarm_o <= 1'b0;
		end else if (clk_en_i) begin
			secondary_output_cfg_alarm_o <= alarm2_raw_i && (s.secondary_output_cfg_func == secchk_pkg::SECONDARY_OUTPUT_CFG_ALARM2) &&
			                (s.alm2_func != secchk_pkg::ALM_NONE); // RQ7
		end
	end

	// Pv1 conflict reaches the display next cycle
	pv1_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ1
		clk_en_i && c1 |=> err_code_o == secchk_pkg::ERR_PV1_BOTH)
		else $error("code 1 not shown");
	pv2_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ2
		clk_en_i && c2 && !c1 |=> err_code_o == secchk_pkg::ERR_PV2_BOTH)
		else $error("code 2 not shown");
	diff_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ3
		clk_en_i && pv_diff && sp_single |=> err_code_o == secchk_pkg::ERR_DIFF_SRC)
		else $error("code 3 not shown");
	cooling_output_choice_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ4
		clk_en_i && c4 && !(c1 || c2 || c3) |=> err_code_o == secchk_pkg::ERR_COOLING_OUTPUT_CHOICE_CFG)
		else $error("code 4 not shown");
	unit_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ5
		clk_en_i && c5 && !(c1 || c2 || c3 || c4)
		|=> err_code_o == secchk_pkg::ERR_UNIT_DP)
		else $error("code 5 not shown");
	// Alarm-two conflict shows when nothing lower is active
	al2_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ6
		clk_en_i && c6 && !(c1 || c2 || c3 || c4 || c5)
		|=> err_code_o == secchk_pkg::ERR_AL2_NONE)
		else $error("code 6 not shown");
	al2_none_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ7
		clk_en_i && c6 |=> !secondary_output_cfg_alarm_o)
		else $error("output two alarm driven with no function");
	// Exact code, so a broken dwell term cannot hide behind another code
	dwell_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ8
		clk_en_i && c7 && !(c1 || c2 || c3 || c4 || c5 || c6)
		|=> err_code_o == secchk_pkg::ERR_DWELL_BOTH)
		else $error("code 7 not shown");
	bad_write_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ12
		clk_en_i && req_i.valid && req_i.write && reg_ro_i[lim_idx_o]
		|=> !wr_commit_o)
		else $error("read-only write committed");
	func_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ9
		clk_en_i && req_i.valid && req_i.func != secchk_pkg::FC_READ
		&& req_i.func != secchk_pkg::FC_WRITE
		|=> resp_o.done && resp_o.code == secchk_pkg::ERR_BAD_FUNC)
		else $error("bad function code not flagged");

	// Request qualifiers for the checks below, kept apart from the classifier
	logic fc_ok;   // Function code accepted
	logic addr_ok; // Address inside the implemented range
	assign fc_ok   = (req_i.func == secchk_pkg::FC_READ) || (req_i.func == secchk_pkg::FC_WRITE);
	assign addr_ok = (req_i.addr < 16'(NREG));

	// Address past the map gets its own code
	addr_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ10
		clk_en_i && req_i.valid && fc_ok && !addr_ok
		|=> resp_o.code == secchk_pkg::ERR_ADDR_RANGE)
		else $error("address range error not flagged");
	// Hole in the parameter map
	param_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ11
		clk_en_i && req_i.valid && fc_ok && addr_ok && !reg_exists_i[lim_idx_o]
		|=> resp_o.code == secchk_pkg::ERR_NO_PARAM)
		else $error("missing parameter not flagged");
	// Write to a read-only item that does exist
	ro_code_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ12
		clk_en_i && req_i.valid && req_i.write && fc_ok && addr_ok
		&& reg_exists_i[lim_idx_o] && reg_ro_i[lim_idx_o]
		|=> resp_o.code == secchk_pkg::ERR_READ_ONLY)
		else $error("read-only write not flagged");
	// Value outside the limits is flagged and never committed
	value_range_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ14
		clk_en_i && req_i.valid && req_i.write && fc_ok && addr_ok
		&& reg_exists_i[lim_idx_o] && !reg_ro_i[lim_idx_o]
		&& (req_i.data < lim_min_i || req_i.data > lim_max_i)
		|=> resp_o.code == secchk_pkg::ERR_VAL_RANGE && !wr_commit_o)
		else $error("out-of-range write not refused");
	// Any setup code takes the display over a held host code
	setup_first_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ15
		clk_en_i && setup_code != secchk_pkg::ERR_NONE
		|=> err_code_o == $past(setup_code))
		else $error("setup code not shown first");
	// Held host code stays until a clear or a new error
	host_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i) // RQ15
		clk_en_i && !resp_o.done && !comm_err_clr_i
		|=> $stable(comm_q))
		else $error("held host code changed");
	// Enable low freezes every registered output
	enable_freeze_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!clk_en_i
		|=> $stable(err_code_o) && $stable(secondary_output_cfg_alarm_o) && $stable(resp_o))
		else $error("state moved with enable low");
endmodule // secchk_top
`default_nettype wire

//--- secchk_host_model.sv
// Host model: issues register read and write requests on the request port.
// Assumes the bench calls its tasks at the falling edge of ref_clk_i.
`default_nettype none
module secchk_host_model (
	input  wire logic                    ref_clk_i, // Device clock
	output var  secchk_pkg::secchk_req_t req_o      // Request towards the device
);
	timeunit 1ns;
	timeprecision 1ns;
	// Quiet port until the first request
	initial req_o = '0;
	// One request driven across the next rising edge and left on the port until the next call; only bad when the bench asks for it
	task automatic issue(input logic w, input logic [7:0] f, input logic [15:0] a,
		input logic [15:0] d);
		req_o.valid = 1'h1;
		req_o.write = w;
		req_o.func  = f;
		req_o.addr  = a;
		req_o.data  = d;
		@(negedge ref_clk_i);
	endtask
	// Released address and data no longer show the last value, so a stale read gets caught
	task automatic idle();
		req_o.valid = 1'h0;
		req_o.addr  = ~req_o.addr;
		req_o.data  = ~req_o.data;
	endtask
endmodule // secchk_host_model
`default_nettype wire

//--- secchk_top_tb.sv
// Bench for the setup error checker: setup cases, then a host request table.
// Assumes the host model drives requests; inputs change at the falling edge.
`default_nettype none
module secchk_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic        w;
		logic [7:0]  f;
		logic [15:0] a;
		logic [15:0] d;
		logic [5:0]  c; // Expected code, 0 when accepted
	} secchk_case_t;
	logic                      ref_clk_i;    // 10 MHz clock
	logic                      sys_rst_i;    // Sync reset
	logic                      alarm2_raw_i; // Loop's alarm two decision
	logic                      comm_err_clr_i; // Host error clear
	logic                      clk_en_i;     // Clock enable under test
	secchk_pkg::secchk_setup_t setup_i;      // Setup under test
	secchk_pkg::secchk_setup_t base;         // Legal setup
	secchk_pkg::secchk_setup_t s;            // Scratch setup
	secchk_pkg::secchk_req_t   req;          // From host model
	secchk_pkg::secchk_resp_t  resp;         // Per-request answer
	logic [5:0]                lim_idx, err_code, held, held_lag;
	logic                      wr_commit, secondary_output_cfg_alarm;
	int                        n_fail = 0;
	int                        tests_run = 0;
	secchk_case_t              tab [14] = '{
		'{1'h0, 8'h03, 16'h0005, 16'h0000, 6'h00}, '{1'h1, 8'h06, 16'h003f, 16'h0100, 6'h00},
		'{1'h1, 8'h06, 16'h0000, 16'h0010, 6'h00}, '{1'h1, 8'h10, 16'h0005, 16'h0020, 6'h0a},
		'{1'h0, 8'h04, 16'h0040, 16'h0000, 6'h0a}, '{1'h0, 8'h03, 16'h0040, 16'h0000, 6'h0b},
		'{1'h1, 8'h06, 16'hffff, 16'h0020, 6'h0b}, '{1'h0, 8'h03, 16'h0007, 16'h0000, 6'h0c},
		'{1'h1, 8'h06, 16'h0007, 16'h0020, 6'h0c}, '{1'h1, 8'h06, 16'h0009, 16'h0020, 6'h0e},
		'{1'h0, 8'h03, 16'h0009, 16'h0000, 6'h00}, '{1'h1, 8'h06, 16'h0005, 16'h0101, 6'h0f},
		'{1'h1, 8'h06, 16'h0005, 16'h000f, 6'h0f}, '{1'h1, 8'h06, 16'h0009, 16'h0200, 6'h0e}};
	// Map: parameter 7 missing, parameter 9 read-only, one value window for all
	secchk_top #(.NREG(64)) secchk_top_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i), .setup_i(setup_i), .alarm2_raw_i(alarm2_raw_i), .req_i(req),
		.reg_exists_i(~64'h80), .reg_ro_i(64'h200), .lim_min_i(16'h0010),
		.lim_max_i(16'h0100), .comm_err_clr_i(comm_err_clr_i), .lim_idx_o(lim_idx),
		.resp_o(resp), .wr_commit_o(wr_commit), .secondary_output_cfg_alarm_o(secondary_output_cfg_alarm),
		.err_code_o(err_code));
	secchk_host_model secchk_host_model_inst (.ref_clk_i(ref_clk_i), .req_o(req));
	// Clock, 100 ns period
	initial begin
		ref_clk_i = 1'h0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	// Compare and count
	task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Apply a setup and look one cycle later, the stated lag
	task automatic setc(input secchk_pkg::secchk_setup_t v, input logic [5:0] exp);
		@(negedge ref_clk_i);
		setup_i = v;
		@(negedge ref_clk_i);
		chk(err_code, exp);
	endtask
	// Single place where the run ends
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog sized well past the roughly 60 cycles the tests need
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		n_fail++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		base = '0;
		base.sp_src = secchk_pkg::SRC_OTHER;
		base.pb_a = 16'h0010;
		base.pb_b = 16'h0010;
		base.ti_a = 16'h0010;
		base.ti_b = 16'h0010;
		setup_i = base;
		sys_rst_i = 1'h1;
		alarm2_raw_i = 1'h1;
		comm_err_clr_i = 1'h0;
		clk_en_i = 1'h1;
		repeat (6) @(negedge ref_clk_i);
		sys_rst_i = 1'h0;
		chk(err_code, 6'h00);
		s = base;
		s.sp_src = secchk_pkg::SRC_FIRST_INPUT;
		setc(s, 6'h01);
		s.alm1_func = secchk_pkg::ALM_DWELL;
		s.alm2_func = secchk_pkg::ALM_DWELL;
		setc(s, 6'h01);
		s.sp_src = secchk_pkg::SRC_OTHER;
		setc(s, 6'h07);
		s = base;
		s.pv_src = secchk_pkg::SRC_SECOND_INPUT;
		s.sp_src = secchk_pkg::SRC_SECOND_INPUT;
		setc(s, 6'h02);
		s.pv_src = secchk_pkg::SRC_DIFF_2M1;
		setc(s, 6'h03);
		s.sp_src = secchk_pkg::SRC_OTHER;
		s.in2_unit = 2'h1;
		setc(s, 6'h05);
		s.pv_src = secchk_pkg::SRC_FIRST_INPUT;
		setc(s, 6'h00);
		s.alm2_func = secchk_pkg::ALM_DIFF_LOW;
		setc(s, 6'h05);
		s = base;
		s.secondary_output_cfg_func = secchk_pkg::SECONDARY_OUTPUT_CFG_COOLING;
		setc(s, 6'h00);
		s.ti_b = 16'h0000;
		setc(s, 6'h04);
		s.ti_b = 16'h0010;
		s.primary_output_cfg_action = secchk_pkg::PRIMARY_OUTPUT_CFG_DIRECT;
		setc(s, 6'h04);
		s = base;
		s.secondary_output_cfg_func = secchk_pkg::SECONDARY_OUTPUT_CFG_ALARM2;
		setc(s, 6'h06);
		chk(6'(secondary_output_cfg_alarm), 6'h00);
		s.alm2_func = secchk_pkg::ALM_COMB_HIGH;
		setc(s, 6'h00);
		chk(6'(secondary_output_cfg_alarm), 6'h01);
		setc(base, 6'h00);
		$display("test setup done");
		// Back-to-back requests; the panel shows a host code three cycles after its request
		held = 6'h00;
		held_lag = 6'h00;
		for (int k = 0; k < 14; k++) begin
			secchk_host_model_inst.issue(tab[k].w, tab[k].f, tab[k].a, tab[k].d);
			chk(6'(resp.done), 6'h01);
			chk(resp.code, tab[k].c);
			chk(6'(resp.accepted), 6'(tab[k].c == 6'h00 && tab[k].w));
			chk(6'(wr_commit), 6'(tab[k].c == 6'h00 && tab[k].w));
			chk(err_code, held_lag);
			held_lag = held;
			if (tab[k].c != 6'h00)
				held = tab[k].c;
		end
		secchk_host_model_inst.idle();
		@(negedge ref_clk_i);
		chk(err_code, held_lag);
		chk(6'(resp.done), 6'h00);
		@(negedge ref_clk_i);
		chk(err_code, 6'h0e);
		// Alarm two back to no function, so code 6 must mask the held host code
		s.alm2_func = secchk_pkg::ALM_NONE;
		setc(s, 6'h06);
		setc(base, 6'h0e);
		comm_err_clr_i = 1'h1;
		repeat (2) @(negedge ref_clk_i);
		chk(err_code, 6'h00);
		comm_err_clr_i = 1'h0;
		$display("test host done");
		// Enable low: a new setup conflict must not reach the display until released
		clk_en_i = 1'h0;
		setup_i = s;
		repeat (2) @(negedge ref_clk_i);
		chk(err_code, 6'h00);
		clk_en_i = 1'h1;
		@(negedge ref_clk_i);
		chk(err_code, 6'h06);
		$display("test enable done");
		tally_and_finish();
	end
endmodule // secchk_top_tb
`default_nettype wire
